// File: src/tsc_pkg.sv
// constants shared by the temperature conversion control block
// assumes a single 25 MHz clock and byte-wide registers behind a two-wire port
package tsc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned T_CONV_NORMAL_MS = 240;
  localparam int unsigned T_CONV_FAST_MS = 6;
  localparam int unsigned T_CONV_SPS_MS = 60;
  localparam int unsigned T_SPS_IDLE_MS = 940;
  localparam int unsigned T_WAKE_MS = 1;
  localparam int unsigned CYC_CONV_NORMAL = T_CONV_NORMAL_MS * CLK_KHZ;
  localparam int unsigned CYC_CONV_FAST = T_CONV_FAST_MS * CLK_KHZ;
  localparam int unsigned CYC_CONV_SPS = T_CONV_SPS_MS * CLK_KHZ;
  localparam int unsigned CYC_SPS_IDLE = T_SPS_IDLE_MS * CLK_KHZ;
  localparam int unsigned CYC_WAKE = T_WAKE_MS * CLK_KHZ;
  localparam int CNT_W = 25;

  // ----------------------------------------------------------------
  // register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_TEMP_MSB = 8'h00;
  localparam logic [7:0] REG_TEMP_LSB = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_HIGH_MSB = 8'h04;
  localparam logic [7:0] REG_HIGH_LSB = 8'h05;
  localparam logic [7:0] REG_LOW_MSB = 8'h06;
  localparam logic [7:0] REG_LOW_LSB = 8'h07;
  localparam logic [7:0] REG_CRIT_MSB = 8'h08;
  localparam logic [7:0] REG_CRIT_LSB = 8'h09;
  localparam logic [7:0] REG_HYST = 8'h0A;
  localparam logic [7:0] REG_ID = 8'h0B;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [15:0] RST_HIGH = 16'h2000;
  localparam logic [15:0] RST_LOW = 16'h0500;
  localparam logic [15:0] RST_CRIT = 16'h4980;
  localparam logic [3:0] RST_HYST = 4'h5;
  localparam int CFG_RES16 = 7;
  localparam int CFG_MODE_HI = 6;
  localparam int CFG_MODE_LO = 5;
  localparam int CFG_IRQ_MODE = 4;
  localparam int CFG_INT_POL = 3;
  localparam int CFG_CT_POL = 2;
  localparam int HYST_SHIFT = 7;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_SPS = 2'b10,
    MODE_SHUTDOWN = 2'b11
  } tsc_mode_t;

endpackage

// File: src/tsc_alarm_if.sv
// bundle between the control block and its limit judge
// assumes both ends share ref_clk
`timescale 1ns/100ps
interface tsc_alarm_if;
  logic done;
  logic [15:0] code;
  logic [15:0] high;
  logic [15:0] low;
  logic [15:0] crit;
  logic [3:0] hyst;
  logic [1:0] queue_sel;
  logic upd;
  logic fire;
  logic [2:0] flags;
  logic int_ok;
  logic ct_ok;
  modport ctrl (output done, code, high, low, crit, hyst, queue_sel,
                input upd, fire, flags, int_ok, ct_ok);
  modport judge (input done, code, high, low, crit, hyst, queue_sel,
                 output upd, fire, flags, int_ok, ct_ok);
endinterface

// File: src/tsc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
// assumes the caller reads only sync_out
`timescale 1ns/100ps
module tsc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // tsc_sync

// File: src/tsc_fault_judge.sv
// limit comparison and fault queue for each finished conversion
// assumes done is a one-cycle pulse carrying the new code
`timescale 1ns/100ps
module tsc_fault_judge
  import tsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  tsc_alarm_if.judge al
);
  logic signed [16:0] code_s, high_s, low_s, crit_s, hyst_s;
  logic v_crit, v_high, v_low, viol;
  logic [2:0] cnt_q;
  logic [2:0] need;

  // ----------------------------------------------------------------
  // compare codes directly
  // ----------------------------------------------------------------
  always_comb begin
    code_s = {al.code[15], al.code};
    high_s = {al.high[15], al.high};
    low_s = {al.low[15], al.low};
    crit_s = {al.crit[15], al.crit};
    hyst_s = 17'({al.hyst, 7'h00}); // 1 degree per 128 code steps, a shift by HYST_SHIFT
    v_crit = code_s > crit_s;
    v_high = code_s > high_s;
    v_low = code_s < low_s;
    viol = v_crit | v_high | v_low;
    need = 3'({1'b0, al.queue_sel}) + 3'h1;
  end

  // ----------------------------------------------------------------
  // fault queue
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
      al.fire <= 1'b0;
      al.upd <= 1'b0;
      al.flags <= 3'h0;
      al.int_ok <= 1'b0;
      al.ct_ok <= 1'b0;
    end else begin
      al.upd <= al.done;
      al.fire <= al.done & viol & ((cnt_q + 3'h1) >= need);
      if (al.done) begin
        cnt_q <= !viol ? 3'h0 : (cnt_q >= need ? need : cnt_q + 3'h1);
        al.flags <= {v_crit, v_high, v_low};
        al.int_ok <= (code_s < high_s - hyst_s) && (code_s > low_s + hyst_s);
        al.ct_ok <= code_s < crit_s - hyst_s;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_queue_reset: assert property (al.done && !viol |=> cnt_q == 3'h0 && !al.fire)
    else $error("fault count not cleared by a clean conversion");
  chk_queue_gate: assert property (al.done && cnt_q == 3'h0 && need > 3'h1 |=> !al.fire)
    else $error("alarm fired before queue depth reached");
endmodule // tsc_fault_judge

// File: src/tsc_conv_ctrl.sv
// Contract
// - normal mode converts back to back, 240 ms
// - each result stored, latest one read
// - first conversion after power-up is 6 ms
// - default limits alarm above 147 and 64
// - compare result with critical, high, low
// - configurable alarm polarity and interrupt/comparator
// - one-shot code converts once then shuts down
// - each one-shot write starts fresh conversion
// - interrupt behaviour: any read clears alarms
// - one-shot comparator: mode write clears interrupt
// - one-shot comparator: mode write clears critical
// - once per second: 60 ms convert, 940 idle
// - shutdown starts no conversions
// - leaving shutdown: 1 ms wake then convert; only a move to normal mode waits, one-shot and once-per-second convert at once
// - result stays readable in shutdown
// - fault queue counts consecutive violations, max four
// - 13-bit result with three flag bits
// - bit 7 selects full 16-bit result
// - setpoints share result format
// - pointer advances after each byte read
//
// conversion sequencing, registers and two-wire slave of a temperature sensor
// assumes temp_sample is a 16-bit code from the analog front end on ref_clk
`timescale 1ns/100ps
module tsc_conv_ctrl
  import tsc_pkg::*;
#(
  parameter int unsigned CONV_NORMAL_CYC = CYC_CONV_NORMAL,
  parameter int unsigned CONV_FAST_CYC = CYC_CONV_FAST,
  parameter int unsigned CONV_SPS_CYC = CYC_CONV_SPS,
  parameter int unsigned SPS_IDLE_CYC = CYC_SPS_IDLE,
  parameter int unsigned WAKE_CYC = CYC_WAKE,
  parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary value
  parameter logic [4:0] DEV_ADDR_HI = 5'h0B // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_sel_in,
  input wire logic [15:0] temp_sample,
  output logic critical_alarm_out,
  output logic interrupt_alarm_out,
  output logic conv_active
);

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  tsc_sync #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({addr_sel_in, scl_in, sda_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_WR, I2C_ACK_W, I2C_RD, I2C_RACK
  } tsc_i2c_t;
  typedef enum logic [1:0] {SQ_OFF, SQ_WAKE, SQ_CONV, SQ_IDLE} tsc_seq_t;

  tsc_i2c_t st_q;
  tsc_seq_t sq_q;
  tsc_mode_t mode_q, mode_new;
  logic [7:0] cfg_q, ptr_q, sh_q, rd_byte;
  logic [15:0] temp_q, high_q, low_q, crit_q;
  logic [3:0] hyst_q, bc_q;
  logic rw_q, first_q, mode_wr_q, rdy_n_q, fast_q, done_q;
  logic int_act_q, ct_act_q;
  logic wr_stb, rd_stb, restart, irq_mode;
  logic [CNT_W-1:0] cnt_q, conv_last;

  tsc_alarm_if al ();

  tsc_fault_judge u_judge (
    .ref_clk(ref_clk),
    .rst(rst),
    .al(al)
  );

  assign mode_new = tsc_mode_t'(cfg_q[CFG_MODE_HI:CFG_MODE_LO]);
  assign irq_mode = cfg_q[CFG_IRQ_MODE];
  assign wr_stb = scl_fall && st_q == I2C_WR && bc_q == 4'h8 && !first_q;
  assign rd_stb = scl_fall && ((st_q == I2C_ACK_A && rw_q) || st_q == I2C_RACK);
  assign restart = (stop_det | start_det) & mode_wr_q;

  // read data mux
  always_comb begin
    case (ptr_q)
      REG_TEMP_MSB: rd_byte = temp_q[15:8];
      REG_TEMP_LSB: rd_byte = cfg_q[CFG_RES16] ? temp_q[7:0]
                                               : {temp_q[7:3], al.flags};
      REG_STATUS: rd_byte = {rdy_n_q, al.flags, 4'h0};
      REG_CONFIG: rd_byte = cfg_q;
      REG_HIGH_MSB: rd_byte = high_q[15:8];
      REG_HIGH_LSB: rd_byte = high_q[7:0];
      REG_LOW_MSB: rd_byte = low_q[15:8];
      REG_LOW_LSB: rd_byte = low_q[7:0];
      REG_CRIT_MSB: rd_byte = crit_q[15:8];
      REG_CRIT_LSB: rd_byte = crit_q[7:0];
      REG_HYST: rd_byte = {4'h0, hyst_q};
      REG_ID: rd_byte = ID_CODE;
      default: rd_byte = 8'h00;
    endcase
  end

  // host writes; defaults give 147 and 64 degree alarms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= RST_CONFIG;
      high_q <= RST_HIGH;
      low_q <= RST_LOW;
      crit_q <= RST_CRIT;
      hyst_q <= RST_HYST;
    end else if (wr_stb) begin
      case (ptr_q)
        REG_CONFIG: cfg_q <= sh_q;
        REG_HIGH_MSB: high_q[15:8] <= sh_q;
        REG_HIGH_LSB: high_q[7:0] <= sh_q;
        REG_LOW_MSB: low_q[15:8] <= sh_q;
        REG_LOW_LSB: low_q[7:0] <= sh_q;
        REG_CRIT_MSB: crit_q[15:8] <= sh_q;
        REG_CRIT_LSB: crit_q[7:0] <= sh_q;
        REG_HYST: hyst_q <= sh_q[3:0];
        default: ;
      endcase
    end
  end

  // a mode write waits for the end of the transfer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_wr_q <= 1'b0;
      mode_q <= MODE_NORMAL;
    end else begin
      if (wr_stb && ptr_q == REG_CONFIG) begin
        mode_wr_q <= 1'b1;
      end else if (restart) begin
        mode_wr_q <= 1'b0;
      end
      if (restart) begin
        mode_q <= mode_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // two-wire slave
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= I2C_IDLE;
      bc_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ptr_q <= RST_PTR;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (start_det) begin
      st_q <= I2C_ADDR;
      bc_q <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st_q <= I2C_IDLE;
      sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      if (st_q == I2C_ADDR || st_q == I2C_WR) begin
        sh_q <= {sh_q[6:0], sda_s};
        bc_q <= bc_q + 4'h1;
      end else if (st_q == I2C_RACK && sda_s) begin
        st_q <= I2C_IDLE;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        I2C_IDLE: ;
        I2C_ADDR: begin
          if (bc_q == 4'h8) begin
            if (sh_q[7:1] == {DEV_ADDR_HI, pins_s[3:2]}) begin
              st_q <= I2C_ACK_A;
              sda_oe_n <= 1'b0;
              rw_q <= sh_q[0];
            end else begin
              st_q <= I2C_IDLE;
            end
          end
        end
        I2C_ACK_A, I2C_RACK: begin
          if (st_q == I2C_RACK || rw_q) begin
            sda_oe_n <= rd_byte[7];
            sh_q <= {rd_byte[6:0], 1'b0};
            ptr_q <= ptr_q + 8'h01;
            bc_q <= 4'h1;
            st_q <= I2C_RD;
          end else begin
            sda_oe_n <= 1'b1;
            bc_q <= 4'h0;
            first_q <= 1'b1;
            st_q <= I2C_WR;
          end
        end
        I2C_WR: begin
          if (bc_q == 4'h8) begin
            sda_oe_n <= 1'b0;
            st_q <= I2C_ACK_W;
            first_q <= 1'b0;
            ptr_q <= first_q ? sh_q : ptr_q + 8'h01;
          end
        end
        I2C_ACK_W: begin
          sda_oe_n <= 1'b1;
          bc_q <= 4'h0;
          st_q <= I2C_WR;
        end
        I2C_RD: begin
          if (bc_q == 4'h8) begin
            sda_oe_n <= 1'b1;
            st_q <= I2C_RACK;
          end else begin
            sda_oe_n <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            bc_q <= bc_q + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    if (fast_q) begin
      conv_last = CNT_W'(CONV_FAST_CYC - 1);
    end else if (mode_q == MODE_SPS) begin
      conv_last = CNT_W'(CONV_SPS_CYC - 1);
    end else begin
      conv_last = CNT_W'(CONV_NORMAL_CYC - 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sq_q <= SQ_CONV;
      cnt_q <= '0;
      fast_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (restart) begin
        cnt_q <= '0;
        fast_q <= 1'b0;
        unique case (mode_new)
          MODE_NORMAL: sq_q <= (mode_q == MODE_SHUTDOWN) ? SQ_WAKE : SQ_CONV;
          MODE_ONESHOT: sq_q <= SQ_CONV;
          MODE_SPS: sq_q <= SQ_CONV;
          MODE_SHUTDOWN: sq_q <= SQ_OFF;
        endcase
      end else begin
        unique case (sq_q)
          SQ_OFF: ;
          SQ_WAKE: begin
            cnt_q <= (cnt_q == CNT_W'(WAKE_CYC - 1)) ? '0 : cnt_q + 1'b1;
            if (cnt_q == CNT_W'(WAKE_CYC - 1)) sq_q <= SQ_CONV;
          end
          SQ_CONV: begin
            if (cnt_q == conv_last) begin
              cnt_q <= '0;
              done_q <= 1'b1;
              fast_q <= 1'b0;
              unique case (mode_q)
                MODE_NORMAL: sq_q <= SQ_CONV;
                MODE_ONESHOT: sq_q <= SQ_OFF;
                MODE_SPS: sq_q <= SQ_IDLE;
                MODE_SHUTDOWN: sq_q <= SQ_OFF;
              endcase
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          SQ_IDLE: begin
            cnt_q <= (cnt_q == CNT_W'(SPS_IDLE_CYC - 1)) ? '0 : cnt_q + 1'b1;
            if (cnt_q == CNT_W'(SPS_IDLE_CYC - 1)) sq_q <= SQ_CONV;
          end
        endcase
      end
    end
  end

  // result capture and ready flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      temp_q <= 16'h0000;
      rdy_n_q <= 1'b1;
      conv_active <= 1'b0;
    end else begin
      conv_active <= sq_q == SQ_CONV;
      if (sq_q == SQ_CONV && cnt_q == conv_last && !restart) begin
        temp_q <= temp_sample;
      end
      if (done_q) begin
        rdy_n_q <= 1'b0;
      end else if (rd_stb && (ptr_q == REG_TEMP_MSB || ptr_q == REG_TEMP_LSB)) begin
        rdy_n_q <= 1'b1;
      end else if (restart && (mode_new == MODE_ONESHOT || mode_new == MODE_SPS)) begin
        rdy_n_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm outputs
  // ----------------------------------------------------------------
  assign al.done = done_q;
  assign al.code = cfg_q[CFG_RES16] ? temp_q : {temp_q[15:3], 3'h0};
  assign al.high = high_q;
  assign al.low = low_q;
  assign al.crit = crit_q;
  assign al.hyst = hyst_q;
  assign al.queue_sel = cfg_q[1:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_act_q <= 1'b0;
      ct_act_q <= 1'b0;
    end else begin
      // a fresh alarm wins over any clear in the same cycle
      if (al.fire && (al.flags[1] || al.flags[0])) begin
        int_act_q <= 1'b1;
      end else if (irq_mode ? rd_stb
                            : (al.int_ok && (al.upd || restart))) begin
        int_act_q <= 1'b0;
      end
      if (al.fire && al.flags[2]) begin
        ct_act_q <= 1'b1;
      end else if (irq_mode ? rd_stb
                            : (al.ct_ok && (al.upd || (restart && mode_new == MODE_ONESHOT)))) begin
        ct_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interrupt_alarm_out <= 1'b1;
      critical_alarm_out <= 1'b1;
    end else begin
      interrupt_alarm_out <= cfg_q[CFG_INT_POL] ? int_act_q : ~int_act_q;
      critical_alarm_out <= cfg_q[CFG_CT_POL] ? ct_act_q : ~ct_act_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_conv_store: assert property (sq_q == SQ_CONV && cnt_q == conv_last && !restart
    |=> done_q && temp_q == $past(temp_sample)) else $error("result not stored");
  chk_oneshot_off: assert property (sq_q == SQ_CONV && cnt_q == conv_last && !restart
    && mode_q == MODE_ONESHOT |=> sq_q == SQ_OFF) else $error("one-shot did not stop");
  chk_normal_loop: assert property (done_q && mode_q == MODE_NORMAL && !$past(restart)
    |-> sq_q == SQ_CONV && cnt_q == '0) else $error("normal mode did not continue");
  chk_shutdown_hold: assert property (sq_q == SQ_OFF && !restart
    |=> sq_q == SQ_OFF && !done_q && $stable(temp_q)) else $error("conversion while off");
  chk_wake_start: assert property (restart && mode_new == MODE_NORMAL
    && mode_q == MODE_SHUTDOWN |=> sq_q == SQ_WAKE) else $error("no wake after shutdown");
  chk_read_clears: assert property (rd_stb && irq_mode && !al.fire
    |=> !int_act_q && !ct_act_q) else $error("read did not clear alarms");
  chk_ptr_advance: assert property (rd_stb |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer not advanced after read");
  chk_pin_polarity: assert property (##1 interrupt_alarm_out ==
    ($past(cfg_q[CFG_INT_POL]) ? $past(int_act_q) : !$past(int_act_q)))
    else $error("interrupt pin polarity wrong");
  chk_mode_at_end: assert property (wr_stb && ptr_q == REG_CONFIG
    |=> mode_q == $past(mode_q) || $past(restart)) else $error("mode changed mid transfer");
endmodule // tsc_conv_ctrl

// File: test/tsc_host_model.sv
// two-wire bus master model that reaches the sensor registers
// assumes the bench resolves the open-drain data line from both drivers
`timescale 1ns/100ps
module tsc_host_model #(
  parameter logic [6:0] ADDR = 7'h2D
) (
  input wire logic ref_clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ----------------------------------------------------------------
  // bit level, 8 cycles per bit
  // ----------------------------------------------------------------
  task automatic step(input logic c, input logic d, input int n);
    @(posedge ref_clk);
    scl <= c;
    sda_drv <= d;
    repeat (n - 1) @(posedge ref_clk);
  endtask
  task automatic start();
    step(1'b0, 1'b1, 4);
    step(1'b1, 1'b1, 4);
    step(1'b1, 1'b0, 4);
  endtask
  task automatic stop();
    step(1'b0, 1'b0, 4);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
  endtask
  // nine bits: byte then acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, scl ? sda_drv : tx[i], 2);
      step(1'b0, tx[i], 2);
      step(1'b1, tx[i], 4);
      rx[i] = sda;
    end
  endtask
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    xfer({d, 1'b1}, r);
    stop();
  endtask
  // result fetched as one two-byte read
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [8:0] r;
    start();
    xfer({ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    start();
    xfer({ADDR, 1'b1, 1'b1}, r);
    xfer(9'h1FE, r);
    d[15:8] = r[8:1];
    xfer(9'h1FF, r);
    d[7:0] = r[8:1];
    stop();
  endtask
endmodule // tsc_host_model

// File: test/tsc_conv_ctrl_tb.sv
// self-checking bench for the conversion control block
// assumes shortened conversion counts and a 320 ns bus bit time
`timescale 1ns/100ps
module tsc_conv_ctrl_tb;
  import tsc_pkg::*;
  logic ref_clk, rst, scl, sda_drv, sda, sda_out, sda_oe_n, crit, intr, act;
  logic [15:0] temp, rv;
  logic [1:0] asel;
  int fail_count, check_count, cyc, n;
  assign sda = sda_drv & (sda_oe_n | sda_out);
  tsc_conv_ctrl #(.CONV_NORMAL_CYC(200), .CONV_FAST_CYC(50), .CONV_SPS_CYC(60),
    .SPS_IDLE_CYC(100), .WAKE_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_in(asel),
    .temp_sample(temp), .critical_alarm_out(crit), .interrupt_alarm_out(intr),
    .conv_active(act));
  tsc_host_model host (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results();
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic span(input logic v, output int k);
    for (k = 0; act === v && k < 3000; k++) tick(1);
  endtask
  task automatic set_temp(input logic [15:0] v);
    @(posedge ref_clk);
    temp <= v;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    temp = 16'h2107;
    asel = 2'b01;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    tick(60);
    check(16'(intr), 16'h0000);
    check(16'(crit), 16'h0001);
    host.rd(8'h00, rv);
    check(rv, 16'h2102);
    set_temp(16'h4A00);
    tick(210);
    check(16'(crit), 16'h0000);
    set_temp(16'h1000);
    tick(210);
    check(16'({intr, crit}), 16'h0003);
    host.wr(REG_CONFIG, 8'h03);
    set_temp(16'h4A00);
    tick(640);
    check(16'(crit), 16'h0001);
    tick(170);
    check(16'(crit), 16'h0000);
    set_temp(16'h4A34);
    host.wr(REG_CONFIG, 8'h8C);
    tick(210);
    check(16'({intr, crit}), 16'h0003);
    host.rd(8'h00, rv);
    check(rv, 16'h4A34);
    set_temp(16'h4A00);
    host.wr(REG_CONFIG, 8'h30);
    tick(2);
    check(16'(act), 16'h0001);
    tick(210);
    check(16'({intr, crit, act}), 16'h0000);
    host.rd(8'h00, rv);
    check(rv, 16'h4A06);
    check(16'({intr, crit}), 16'h0003);
    host.wr(REG_CONFIG, 8'h30);
    tick(2);
    check(16'(act), 16'h0001);
    host.wr(REG_CONFIG, 8'h40);
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, n);
    check(16'(n), 16'h003C);
    span(1'b0, n);
    check(16'(n), 16'h0064);
    host.wr(REG_CONFIG, 8'h60);
    tick(3);
    n = 0;
    repeat (300) begin
      tick(1);
      n += int'(act);
    end
    check(16'(n), 16'h0000);
    host.wr(REG_CONFIG, 8'h00);
    span(1'b0, n);
    check(16'(n >= 15 && n <= 25), 16'h0001);
    host.wr(REG_HIGH_MSB, 8'h30);
    host.rd(REG_HIGH_MSB, rv);
    check(rv, 16'h3000);
    host.rd(8'h20, rv);
    check(rv, 16'h0000);
    results();
  end
endmodule // tsc_conv_ctrl_tb
